// *** logic/scfg_map.vh ***
// Constant map of the setup configuration and test mode block.
`ifndef SCFG_MAP_VH
`define SCFG_MAP_VH
// ********************************************
// Setup word layout
// ********************************************
`define SCFG_W 64
`define SCFG_LF_SRC_LSB 0
`define SCFG_LF_SRC_MSB 1
`define SCFG_LF_ACC_LSB 2
`define SCFG_LF_ACC_MSB 4
`define SCFG_HF_SRC_BIT 5
`define SCFG_TXP_LSB 6
`define SCFG_TXP_MSB 7
`define SCFG_DCDC_BIT 8
`define SCFG_ACT_EN_BIT 9
`define SCFG_ACT_POL_BIT 10
`define SCFG_ACT_LEAD_LSB 11
`define SCFG_ACT_LEAD_MSB 17
`define SCFG_CI_MIN_LSB 18
`define SCFG_CI_MIN_MSB 29
`define SCFG_CI_MAX_LSB 30
`define SCFG_CI_MAX_MSB 41
`define SCFG_LAT_LSB 42
`define SCFG_LAT_MSB 51
`define SCFG_TMO_LSB 52
`define SCFG_TMO_MSB 59
`define SCFG_KMIN_LSB 60
`define SCFG_KMIN_MSB 61
`define SCFG_KMAX_LSB 62
`define SCFG_KMAX_MSB 63
// ********************************************
// Encodings and defaults
// ********************************************
`define SCFG_LF_RC 2'h0
`define SCFG_ACC_151_250 3'h1
`define SCFG_HF_XTAL 1'h1
`define SCFG_TXP_0DBM 2'h3
`define SCFG_LEAD_MAX 7'h40
`define SCFG_KEY_MIN 5'h07
`define SCFG_KEY_MAX 5'h10
`define SCFG_KEY_W 5
// Key lengths travel on their own ports, since a two-bit field could not span 7..16.
`define SCFG_DEFAULT 64'h0000_0000_0000_00E4
// ********************************************
// Timing
// ********************************************
`define SCFG_CLK_HZ 25000000
`define SCFG_HF_DIG_US 500
`define SCFG_HF_XTAL_US 1500
`define SCFG_US_DIV 1000000
`define SCFG_TEST_EXIT 2'h0
`define SCFG_TEST_ENTER 2'h1
`define SCFG_TEST_CMD 2'h2
`endif

// *** logic/scfg_sync.v ***
// Two flip-flop synchroniser for a pin level.
`timescale 1ns/10ps
module scfg_sync (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire d_i,
    output reg q_o
);
    reg meta;
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // scfg_sync

// *** logic/scfg_top.v ***
// Setup configuration store and radio test mode control.
// Summary of operation
// - Test mode entered only by host command.
// - Test mode takes two-byte commands, UART or host.
// - Protocol stack disabled during test mode.
// - Exit by host command or reset.
// - Reset loads programmed setup as defaults.
// - Low-frequency source and eight accuracy ranges.
// - High-frequency source with its start time.
// - Four transmit power levels, runtime changeable.
// - Active signal enable, lead, polarity.
// - Preferred connection timing for update requests.
// - Minimum key length 7 to 16, default 7.
// - Maximum key length 7 to 16, default 16.
// - Host picks permanent or volatile setup store.
// - Permanent store is one-time programmable.
// - Volatile setup lost on reset.
// - Runtime data kept only in volatile memory.
`timescale 1ns/10ps
`include "scfg_map.vh"
module scfg_top (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire hci_valid_i,
    input wire [1:0] hci_op_i,
    input wire [15:0] hci_test_word_i,
    input wire setup_wr_i,
    input wire setup_nvm_i,
    input wire [63:0] setup_data_i,
    input wire [4:0] key_min_i,
    input wire [4:0] key_max_i,
    input wire txp_wr_i,
    input wire [1:0] txp_i,
    input wire uart_valid_i,
    input wire [15:0] uart_word_i,
    input wire rt_wr_i,
    input wire [3:0] rt_addr_i,
    input wire [7:0] rt_data_i,
    input wire [3:0] rt_raddr_i,
    output reg test_mode_o,
    output reg stack_en_o,
    output reg radio_cmd_valid_o,
    output reg [15:0] radio_cmd_o,
    output reg nvm_programmed_o,
    output reg setup_volatile_o,
    output reg nvm_wr_refused_o,
    output reg [1:0] lf_src_o,
    output reg [2:0] lf_acc_o,
    output reg hf_src_o,
    output reg hf_ready_o,
    output reg [1:0] txp_o,
    output reg dcdc_en_o,
    output reg act_en_o,
    output reg act_pol_o,
    output reg [6:0] act_lead_o,
    output reg [11:0] ci_min_o,
    output reg [11:0] ci_max_o,
    output reg [9:0] slave_lat_o,
    output reg [7:0] sup_tmo_o,
    output reg [4:0] key_min_o,
    output reg [4:0] key_max_o,
    output reg [7:0] rt_rdata_o
);
    // ********************************************
    // Timing constants
    // ********************************************
    localparam integer HF_DIG_CYC = (`SCFG_CLK_HZ / `SCFG_US_DIV) * `SCFG_HF_DIG_US;
    localparam integer HF_XTAL_CYC = (`SCFG_CLK_HZ / `SCFG_US_DIV) * `SCFG_HF_XTAL_US;
    localparam ST_LOAD = 2'h0;
    localparam ST_HFWAIT = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_TEST = 2'h3;

    // Clamp a key length into the legal 7..16 range.
    function [4:0] clamp_key;
        input [4:0] k;
        begin
            if (k < `SCFG_KEY_MIN)
                clamp_key = `SCFG_KEY_MIN;
            else if (k > `SCFG_KEY_MAX)
                clamp_key = `SCFG_KEY_MAX;
            else
                clamp_key = k;
        end
    endfunction

    // ********************************************
    // Storage
    // ********************************************
    // The permanent store models one-time programmable cells: it survives
    // the synchronous reset, so it has no reset branch at all.
    reg [63:0] nvm_word;
    reg [4:0] nvm_kmin;
    reg [4:0] nvm_kmax;
    // The cells leave the fab unprogrammed; without a start value the store
    // would never leave the unknown state, because reset does not touch it.
    reg nvm_done = 1'b0;
    reg nvm_init = 1'b0;
    reg [63:0] vol_word;
    reg [4:0] vol_kmin;
    reg [4:0] vol_kmax;
    reg vol_valid;
    reg [1:0] state;
    reg [15:0] hf_cnt;
    reg [7:0] rt_mem [0:15];
    wire uart_valid_s;
    wire hci_cmd = hci_valid_i & ce_i;
    wire [63:0] act_word = vol_valid ? vol_word : (nvm_done ? nvm_word : `SCFG_DEFAULT);
    wire [4:0] act_kmin = vol_valid ? vol_kmin : (nvm_done ? nvm_kmin : `SCFG_KEY_MIN);
    wire [4:0] act_kmax = vol_valid ? vol_kmax : (nvm_done ? nvm_kmax : `SCFG_KEY_MAX);
    wire [6:0] lead_in = act_word[`SCFG_ACT_LEAD_MSB:`SCFG_ACT_LEAD_LSB];

    scfg_sync u_uv (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(uart_valid_i),
        .q_o(uart_valid_s)
    );

    // ********************************************
    // Permanent store
    // ********************************************
    always @(posedge ref_clk_i) begin
        if (ce_i && !nvm_init) begin
            nvm_init <= 1'b1;
            nvm_done <= 1'b0;
        end else if (ce_i && setup_wr_i && setup_nvm_i && !nvm_done) begin
            nvm_word <= setup_data_i;
            nvm_kmin <= clamp_key(key_min_i);
            nvm_kmax <= clamp_key(key_max_i);
            nvm_done <= 1'b1;
        end
    end

    // ********************************************
    // Volatile store and runtime data
    // ********************************************
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            vol_valid <= 1'b0;
            vol_word <= `SCFG_DEFAULT;
            vol_kmin <= `SCFG_KEY_MIN;
            vol_kmax <= `SCFG_KEY_MAX;
        end else if (ce_i && setup_wr_i && !setup_nvm_i) begin
            vol_valid <= 1'b1;
            vol_word <= setup_data_i;
            vol_kmin <= clamp_key(key_min_i);
            vol_kmax <= clamp_key(key_max_i);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_rt
            always @(posedge ref_clk_i) begin
                if (!rstn_i)
                    rt_mem[gi] <= 8'h00;
                else if (ce_i && rt_wr_i && rt_addr_i == gi)
                    rt_mem[gi] <= rt_data_i;
            end
        end
    endgenerate

    // ********************************************
    // Control sequence and applied setup
    // ********************************************
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state <= ST_LOAD;
            hf_cnt <= 16'h0000;
            test_mode_o <= 1'b0;
            stack_en_o <= 1'b0;
            radio_cmd_valid_o <= 1'b0;
            radio_cmd_o <= 16'h0000;
            nvm_programmed_o <= 1'b0;
            setup_volatile_o <= 1'b0;
            nvm_wr_refused_o <= 1'b0;
            lf_src_o <= `SCFG_LF_RC;
            lf_acc_o <= `SCFG_ACC_151_250;
            hf_src_o <= `SCFG_HF_XTAL;
            hf_ready_o <= 1'b0;
            txp_o <= `SCFG_TXP_0DBM;
            dcdc_en_o <= 1'b0;
            act_en_o <= 1'b0;
            act_pol_o <= 1'b0;
            act_lead_o <= 7'h00;
            ci_min_o <= 12'h000;
            ci_max_o <= 12'h000;
            slave_lat_o <= 10'h000;
            sup_tmo_o <= 8'h00;
            key_min_o <= `SCFG_KEY_MIN;
            key_max_o <= `SCFG_KEY_MAX;
            rt_rdata_o <= 8'h00;
        end else if (ce_i) begin
            radio_cmd_valid_o <= 1'b0;
            rt_rdata_o <= rt_mem[rt_raddr_i];
            nvm_programmed_o <= nvm_done;
            setup_volatile_o <= vol_valid;
            // Pulse when a second permanent write is dropped.
            nvm_wr_refused_o <= setup_wr_i & setup_nvm_i & nvm_done;
            if (txp_wr_i)
                txp_o <= txp_i;
            case (state)
                ST_LOAD: begin
                    lf_src_o <= act_word[`SCFG_LF_SRC_MSB:`SCFG_LF_SRC_LSB];
                    // Internal RC pins the accuracy to the 151..250 ppm range.
                    if (act_word[`SCFG_LF_SRC_MSB:`SCFG_LF_SRC_LSB] == `SCFG_LF_RC)
                        lf_acc_o <= `SCFG_ACC_151_250;
                    else
                        lf_acc_o <= act_word[`SCFG_LF_ACC_MSB:`SCFG_LF_ACC_LSB];
                    hf_src_o <= act_word[`SCFG_HF_SRC_BIT];
                    txp_o <= act_word[`SCFG_TXP_MSB:`SCFG_TXP_LSB];
                    dcdc_en_o <= act_word[`SCFG_DCDC_BIT];
                    act_en_o <= act_word[`SCFG_ACT_EN_BIT];
                    act_pol_o <= act_word[`SCFG_ACT_POL_BIT];
                    act_lead_o <= (lead_in > `SCFG_LEAD_MAX) ? `SCFG_LEAD_MAX : lead_in;
                    ci_min_o <= act_word[`SCFG_CI_MIN_MSB:`SCFG_CI_MIN_LSB];
                    ci_max_o <= act_word[`SCFG_CI_MAX_MSB:`SCFG_CI_MAX_LSB];
                    slave_lat_o <= act_word[`SCFG_LAT_MSB:`SCFG_LAT_LSB];
                    sup_tmo_o <= act_word[`SCFG_TMO_MSB:`SCFG_TMO_LSB];
                    key_min_o <= act_kmin;
                    key_max_o <= act_kmax;
                    hf_cnt <= act_word[`SCFG_HF_SRC_BIT] ? HF_XTAL_CYC[15:0] : HF_DIG_CYC[15:0];
                    state <= ST_HFWAIT;
                end
                ST_HFWAIT: begin
                    // Stack waits out the reference clock start time.
                    if (hf_cnt <= 16'h0001) begin
                        hf_ready_o <= 1'b1;
                        stack_en_o <= 1'b1;
                        state <= ST_RUN;
                    end else
                        hf_cnt <= hf_cnt - 16'h0001;
                end
                ST_RUN: begin
                    if (setup_wr_i && !(setup_nvm_i && nvm_done)) begin
                        state <= ST_LOAD;
                        stack_en_o <= 1'b0;
                        hf_ready_o <= 1'b0;
                    end else if (hci_cmd && hci_op_i == `SCFG_TEST_ENTER) begin
                        test_mode_o <= 1'b1;
                        stack_en_o <= 1'b0;
                        state <= ST_TEST;
                    end
                end
                ST_TEST: begin
                    if (hci_cmd && hci_op_i == `SCFG_TEST_EXIT) begin
                        test_mode_o <= 1'b0;
                        stack_en_o <= 1'b1;
                        state <= ST_RUN;
                    end else if (hci_cmd && hci_op_i == `SCFG_TEST_CMD) begin
                        radio_cmd_valid_o <= 1'b1;
                        radio_cmd_o <= hci_test_word_i;
                    end else if (uart_valid_s) begin
                        radio_cmd_valid_o <= 1'b1;
                        radio_cmd_o <= uart_word_i;
                    end
                end
                default: state <= ST_LOAD;
            endcase
        end
    end
endmodule // scfg_top

// *** verification/scfg_top_monitor.sv ***
// Checker bound to the setup store and radio test mode block.
`timescale 1ns/10ps
module scfg_top_monitor (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire hci_valid_i,
    input wire [1:0] hci_op_i,
    input wire [15:0] hci_test_word_i,
    input wire setup_wr_i,
    input wire setup_nvm_i,
    input wire test_mode_o,
    input wire stack_en_o,
    input wire radio_cmd_valid_o,
    input wire [15:0] radio_cmd_o,
    input wire nvm_programmed_o,
    input wire setup_volatile_o,
    input wire nvm_wr_refused_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_enter_test: assert property (hci_valid_i && ce_i && hci_op_i == 2'h1 && stack_en_o
        |=> test_mode_o && !stack_en_o) else $error("enter failed");
    a_stack_off: assert property (test_mode_o |-> !stack_en_o) else $error("stack on");
    a_exit_test: assert property (hci_valid_i && ce_i && hci_op_i == 2'h0 && test_mode_o
        |=> !test_mode_o && stack_en_o) else $error("exit failed");
    a_host_word: assert property (hci_valid_i && ce_i && hci_op_i == 2'h2 && test_mode_o
        |=> radio_cmd_valid_o && radio_cmd_o == $past(hci_test_word_i)) else $error("bad word");
    a_word_gate: assert property (radio_cmd_valid_o |-> $past(test_mode_o)) else $error("word");
    a_reset_clear: assert property (disable iff (1'b0) !rstn_i && ce_i
        |=> !test_mode_o && !setup_volatile_o) else $error("reset");
    a_nvm_kept: assert property (nvm_programmed_o |=> nvm_programmed_o) else $error("otp");
    a_nvm_refuse: assert property (setup_wr_i && ce_i && setup_nvm_i && nvm_programmed_o
        && stack_en_o |=> nvm_wr_refused_o) else $error("no refusal");
endmodule // scfg_top_monitor
bind scfg_top scfg_top_monitor u_mon (.*);

// *** verification/scfg_host_model.sv ***
// Behavioural host processor that issues commands and setup writes.
`timescale 1ns/10ps
module scfg_host_model (
    input wire ref_clk_i,
    output logic hci_valid_o = 1'b0,
    output logic [1:0] hci_op_o = 2'h3,
    output logic [15:0] hci_test_word_o = 16'h0000,
    output logic setup_wr_o = 1'b0,
    output logic setup_nvm_o = 1'b0,
    output logic [63:0] setup_data_o = 64'h0,
    output logic [4:0] key_min_o = 5'h07,
    output logic [4:0] key_max_o = 5'h10
);
    // Released data is inverted so that a stale value cannot pass unnoticed.
    task automatic done;
        @(posedge ref_clk_i);
        hci_valid_o <= 1'b0;
        setup_wr_o <= 1'b0;
        hci_op_o <= 2'h3;
        hci_test_word_o <= ~hci_test_word_o;
        setup_data_o <= ~setup_data_o;
    endtask
    task automatic cmd(input logic [1:0] op, input logic [15:0] w);
        @(posedge ref_clk_i);
        hci_valid_o <= 1'b1;
        hci_op_o <= op;
        hci_test_word_o <= w;
        done();
    endtask
    task automatic setup(input logic nvm, input logic [63:0] d, input logic [4:0] kn,
        input logic [4:0] kx);
        @(posedge ref_clk_i);
        setup_wr_o <= 1'b1;
        setup_nvm_o <= nvm;
        setup_data_o <= d;
        key_min_o <= kn;
        key_max_o <= kx;
        done();
    endtask
endmodule // scfg_host_model

// *** verification/tb.sv ***
// Self-checking bench for the setup store and radio test mode block.
`timescale 1ns/10ps
module tb;
    localparam logic [63:0] W1 = {4'h0, 8'h64, 10'h003, 12'h0C8, 12'h006, 7'h40, 5'h1D, 6'h1F};
    localparam logic [63:0] W2 = {4'h0, 8'h0A, 10'h000, 12'h020, 12'h010, 7'h01, 5'h0A, 6'h14};
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic uart_valid_i = 1'b0;
    logic [15:0] uart_word_i = 16'h3C96;
    logic rt_wr_i = 1'b0;
    logic [7:0] rt_data_i = 8'hA5;
    logic txp_wr_i = 1'b0;
    logic [1:0] txp_i = 2'h0;
    wire hci_valid_i, setup_wr_i, setup_nvm_i, test_mode_o, stack_en_o, radio_cmd_valid_o;
    wire nvm_programmed_o, setup_volatile_o, nvm_wr_refused_o, hf_ready_o;
    wire [1:0] hci_op_i;
    wire [15:0] hci_test_word_i, radio_cmd_o;
    wire [63:0] setup_data_i;
    wire [4:0] key_min_i, key_max_i, key_min_o, key_max_o;
    wire [7:0] rt_rdata_o;
    wire [59:0] cfg;
    int checked = 0;
    int n_mismatch = 0;
    int cycles = 0;
    int i;
    always #20 ref_clk_i = ~ref_clk_i;
    scfg_host_model u_host (.ref_clk_i(ref_clk_i), .hci_valid_o(hci_valid_i),
        .hci_op_o(hci_op_i), .hci_test_word_o(hci_test_word_i), .setup_wr_o(setup_wr_i),
        .setup_nvm_o(setup_nvm_i), .setup_data_o(setup_data_i), .key_min_o(key_min_i),
        .key_max_o(key_max_i));
    scfg_top u_dut (.*, .rt_addr_i(4'h5), .rt_raddr_i(4'h5), .lf_src_o(cfg[1:0]),
        .lf_acc_o(cfg[4:2]), .hf_src_o(cfg[5]), .txp_o(cfg[7:6]), .dcdc_en_o(cfg[8]),
        .act_en_o(cfg[9]), .act_pol_o(cfg[10]), .act_lead_o(cfg[17:11]),
        .ci_min_o(cfg[29:18]), .ci_max_o(cfg[41:30]), .slave_lat_o(cfg[51:42]),
        .sup_tmo_o(cfg[59:52]));
    task automatic chk(input string what, input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask
    // The start-up delay is measured, so a wrong clock source shows as a wrong wait.
    task automatic wait_run(input int n);
        int k;
        repeat (2) step();
        for (k = 0; k < 40000 && stack_en_o !== 1'b1; k++) step();
        chk("hf_wait", k > n - 12 && k < n + 12, 1);
        chk("hf_ready", hf_ready_o, 1);
    endtask
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        wait_run(37500);
        chk("dflt", {key_max_o, key_min_o, cfg}, {5'h10, 5'h07, 60'hE4});
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            txp_wr_i <= 1'b1;
            txp_i <= i[1:0];
            @(posedge ref_clk_i);
            txp_wr_i <= 1'b0;
            #1;
            chk("txp", cfg[7:6], i);
        end
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        txp_wr_i <= 1'b1;
        txp_i <= 2'h0;
        @(posedge ref_clk_i);
        txp_wr_i <= 1'b0;
        ce_i <= 1'b1;
        #1;
        chk("txp_frozen", cfg[7:6], 2'h3);
        $display("test power done");
        u_host.cmd(2'h1, 16'h0000);
        #1;
        chk("enter", {test_mode_o, stack_en_o}, 2'b10);
        u_host.cmd(2'h2, 16'hA55A);
        #1;
        chk("host_word", {radio_cmd_valid_o, radio_cmd_o}, 17'h1A55A);
        @(posedge ref_clk_i);
        uart_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        uart_valid_i <= 1'b0;
        for (i = 0; i < 8 && radio_cmd_valid_o !== 1'b1; i++) step();
        chk("uart_word", {radio_cmd_valid_o, radio_cmd_o}, 17'h13C96);
        u_host.cmd(2'h0, 16'h0000);
        #1;
        chk("exit", {test_mode_o, stack_en_o}, 2'b01);
        u_host.cmd(2'h2, 16'h1111);
        #1;
        chk("word_in_run", radio_cmd_valid_o, 0);
        @(posedge ref_clk_i);
        rt_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        rt_wr_i <= 1'b0;
        rt_data_i <= 8'h5A;
        step();
        chk("rt_read", rt_rdata_o, 8'hA5);
        $display("test mode done");
        u_host.setup(1'b0, W1, 5'h03, 5'h14);
        wait_run(12500);
        chk("volatile", {setup_volatile_o, key_max_o, key_min_o, cfg},
            {1'b1, 5'h10, 5'h07, W1[59:0]});
        u_host.setup(1'b1, W2, 5'h09, 5'h0C);
        wait_run(12500);
        chk("precedence", {nvm_programmed_o, cfg}, {1'b1, W1[59:0]});
        u_host.setup(1'b1, ~W1, 5'h08, 5'h08);
        #1;
        chk("refused", nvm_wr_refused_o, 1);
        $display("test store done");
        u_host.cmd(2'h1, 16'h0000);
        rstn_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        #1;
        chk("reset", {test_mode_o, setup_volatile_o}, 2'b00);
        wait_run(12500);
        chk("reload", cfg, {W2[59:5], 3'h1, W2[1:0]});
        chk("kept", {nvm_programmed_o, key_max_o, key_min_o, rt_rdata_o}, 19'h58900);
        $display("test reset done");
        final_report();
    end
endmodule // tb
